// ===== fhp_pkg.sv
// Operation
// - Pin reset idles port, clears registers except timers
// - Strobes act only while chip select or DMA grant asserted
// - Three address lines pick the host registers
// - DMA request high; gated float in PC mode
// - Interrupt for non-DMA transfers and result status
// - DMA grant qualifies strobes instead of select
// - Terminal count ends transfer only during grant
// - Terminal count high in PC mode, else low
// - Timing derived from a 24 MHz tick
// - Identity strap picks PC mode and gating
// - All registers present in either mode
package fhp_pkg;

	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned OSC_MHZ = 24;

	localparam int unsigned RST_WIDTH_TCY = 14;

	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;

	localparam logic [2:0] ADDR_STATUS_A = 3'h0;
	localparam logic [2:0] ADDR_STATUS_B = 3'h1;
	localparam logic [2:0] ADDR_DOR      = 3'h2;
	localparam logic [2:0] ADDR_RSVD_3   = 3'h3;
	localparam logic [2:0] ADDR_MSR_DSR  = 3'h4;
	localparam logic [2:0] ADDR_FIFO     = 3'h5;
	localparam logic [2:0] ADDR_RSVD_6   = 3'h6;
	localparam logic [2:0] ADDR_DIR_CCR  = 3'h7;

	localparam logic [7:0] DOR_RESET = 8'h00;
	localparam logic [7:0] DSR_RESET = 8'h00;
	localparam logic [7:0] CCR_RESET = 8'h00;
	localparam logic [7:0] HUT_RESET = 8'h00;
	localparam logic [7:0] IDLE_DATA = 8'h00;

	localparam int unsigned DOR_GATE_BIT = 3;
	localparam int unsigned SRA_INT_BIT  = 7;

	// Synchronised pin bundle width: 7 single pins, address, data
	localparam int unsigned PIN_W = 7 + ADDR_W + DATA_W;

endpackage

// ===== fhp_pin_if.sv
interface fhp_pin_if;
	import fhp_pkg::*;

	logic              cs_n;
	logic              rd_n;
	logic              wr_n;
	logic              dma_grant_in_n;
	logic              tc;
	logic              ident;
	logic              rst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] db;

	modport src (
		output cs_n,
		output rd_n,
		output wr_n,
		output dma_grant_in_n,
		output tc,
		output ident,
		output rst,
		output addr,
		output db
	);

	modport dst (
		input cs_n,
		input rd_n,
		input wr_n,
		input dma_grant_in_n,
		input tc,
		input ident,
		input rst,
		input addr,
		input db
	);
endinterface

// ===== fhp_sync.sv
module fhp_sync
	import fhp_pkg::*;
#(
	parameter int unsigned W = PIN_W
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] raw_i,
	output logic      [W-1:0] q_o
);
	if (W < 1) begin : g_chk
		$error("fhp_sync: width must be at least one");
	end

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} fhp_sync_state_type;

	fhp_sync_state_type st;
	fhp_sync_state_type next_st;

	always_comb begin
		next_st    = st;
		next_st.s1 = raw_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// A bit moves only once the second and third stages agree
		next_st.q  = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.q);
		// Reset flushes the pins straight through so straps are caught settled
		if (srst_i) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign q_o = st.q;
endmodule

// ===== fhp_tick.sv
module fhp_tick
	import fhp_pkg::*;
#(
	parameter int unsigned NUM = OSC_MHZ,
	parameter int unsigned DEN = CLK_MHZ
) (
	input  wire logic clk_i,
	input  wire logic srst_i,
	output logic      tick_o
);
	if (NUM == 0 || NUM >= DEN || DEN > 255) begin : g_chk
		$error("fhp_tick: need 0 < NUM < DEN <= 255");
	end

	localparam logic [8:0] STEP = 9'(NUM);
	localparam logic [8:0] WRAP = 9'(DEN);

	typedef struct packed {
		logic [8:0] acc;
		logic       tick;
	} fhp_tick_state_type;

	fhp_tick_state_type st;
	fhp_tick_state_type next_st;
	logic [8:0]         sum;

	// Fractional divider: NUM pulses every DEN clocks
	always_comb begin
		sum     = st.acc + STEP;
		next_st = st;
		if (sum >= WRAP) begin
			next_st.acc  = sum - WRAP;
			next_st.tick = 1'b1;
		end else begin
			next_st.acc  = sum;
			next_st.tick = 1'b0;
		end
		if (srst_i) begin
			next_st = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign tick_o = st.tick;
endmodule

// ===== fhp_port.sv
module fhp_port
	import fhp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        reset_pin_i,
	input  wire logic        ident_i,
	input  wire logic        cs_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  data_i,
	output logic      [7:0]  data_o,
	output logic             data_oe_o,
	input  wire logic        dma_grant_in_n_i,
	input  wire logic        transfer_end_count_i,
	output logic             dma_request_out_o,
	output logic             dma_request_out_oe_o,
	output logic             irq_o,
	output logic             irq_oe_o,
	input  wire logic        core_xfer_req_i,
	input  wire logic        core_non_dma_i,
	input  wire logic        core_result_valid_i,
	input  wire logic [7:0]  core_rd_data_i,
	input  wire logic [7:0]  core_status_a_i,
	input  wire logic [7:0]  core_status_b_i,
	input  wire logic [7:0]  core_main_status_i,
	input  wire logic [7:0]  core_drive_input_i,
	input  wire logic        core_spec_load_i,
	input  wire logic [7:0]  core_spec_value_i,
	output logic             core_write_o,
	output logic      [7:0]  core_write_data_o,
	output logic             core_read_o,
	output logic             core_tc_o,
	output logic             port_reset_o,
	output logic             pc_mode_o,
	output logic             osc_tick_o,
	output logic      [7:0]  drive_output_control_o,
	output logic      [7:0]  rate_select_o,
	output logic      [7:0]  config_control_o,
	output logic      [7:0]  head_unload_timer_o
);
	localparam int unsigned RCNT_W = $clog2(RST_WIDTH_TCY + 1);
	localparam logic [RCNT_W-1:0] RCNT_MAX = RCNT_W'(RST_WIDTH_TCY);

	typedef struct packed {
		logic              pc_mode;
		logic              rd_prev;
		logic              wr_prev;
		logic              tc_prev;
		logic [7:0]        drive_output_control;
		logic [7:0]        dsr;
		logic [7:0]        config_control;
		logic [7:0]        head_unload_timer;
		logic [RCNT_W-1:0] rst_cnt;
		logic              soft_rst;
		logic [7:0]        dout;
		logic              dout_oe;
		logic              dma_request_out;
		logic              irq;
		logic              core_wr;
		logic [7:0]        core_wdata;
		logic              core_rd;
		logic              core_tc;
	} fhp_port_state_type;

	fhp_port_state_type st;
	fhp_port_state_type next_st;

	fhp_pin_if pins ();

	logic tick;

	fhp_sync #(
		.W (PIN_W)
	) u_sync (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.raw_i  ({cs_n_i, rd_n_i, wr_n_i, dma_grant_in_n_i, transfer_end_count_i,
			ident_i, reset_pin_i, addr_i, data_i}),
		.q_o    ({pins.cs_n, pins.rd_n, pins.wr_n, pins.dma_grant_in_n, pins.tc,
			pins.ident, pins.rst, pins.addr, pins.db})
	);

	// Internal timing base at the oscillator rate
	fhp_tick #(
		.NUM (OSC_MHZ),
		.DEN (CLK_MHZ)
	) u_tick (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.tick_o (tick)
	);

	logic       grant;
	logic       sel;
	logic       rd_act;
	logic       rd_end;
	logic       wr_end;
	logic       tc_level;
	logic       tc_rise;
	logic [2:0] eff_addr;
	logic [7:0] rd_mux;
	logic       rd_valid;
	logic       gate_float;

	always_comb begin
		grant    = ~pins.dma_grant_in_n;
		// Grant selects the data register; otherwise chip select qualifies
		sel      = grant | ~pins.cs_n;
		eff_addr = grant ? ADDR_FIFO : pins.addr;
		rd_act   = sel & ~pins.rd_n;
		rd_end   = sel & pins.rd_n & ~st.rd_prev;
		wr_end   = sel & pins.wr_n & ~st.wr_prev;
		// Polarity follows the strap-selected mode
		tc_level = st.pc_mode ? pins.tc : ~pins.tc;
		tc_rise  = tc_level & ~st.tc_prev & grant;
		// Output gating exists only in PC mode
		gate_float = st.pc_mode & st.drive_output_control[DOR_GATE_BIT];
	end

	// Read decode; every register answers in both modes
	always_comb begin
		rd_valid = 1'b1;
		case (eff_addr)
			ADDR_STATUS_A: rd_mux = {st.irq, core_status_a_i[SRA_INT_BIT-1:0]};
			ADDR_STATUS_B: rd_mux = core_status_b_i;
			ADDR_DOR:      rd_mux = st.drive_output_control;
			ADDR_MSR_DSR:  rd_mux = core_main_status_i;
			ADDR_FIFO:     rd_mux = core_rd_data_i;
			ADDR_DIR_CCR:  rd_mux = core_drive_input_i;
			default: begin
				rd_mux   = IDLE_DATA;
				rd_valid = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_st         = st;
		next_st.rd_prev = pins.rd_n;
		next_st.wr_prev = pins.wr_n;
		next_st.tc_prev = tc_level;
		next_st.core_wr = 1'b0;
		next_st.core_rd = 1'b0;
		next_st.core_tc = 1'b0;

		// Reset pin must stay high for the minimum width in oscillator periods
		if (!pins.rst) begin
			next_st.rst_cnt  = '0;
			next_st.soft_rst = 1'b0;
		end else if (tick && st.rst_cnt != RCNT_MAX) begin
			next_st.rst_cnt = st.rst_cnt + 1'b1;
		end else if (st.rst_cnt == RCNT_MAX) begin
			next_st.soft_rst = 1'b1;
		end

		// Read data stands while the strobe is held
		next_st.dout_oe = rd_act & rd_valid;
		next_st.dout    = rd_act ? rd_mux : IDLE_DATA;

		if (rd_end && eff_addr == ADDR_FIFO) begin
			next_st.core_rd = 1'b1;
		end

		if (wr_end) begin
			case (eff_addr)
				ADDR_DOR:     next_st.drive_output_control = pins.db;
				ADDR_MSR_DSR: next_st.dsr = pins.db;
				ADDR_DIR_CCR: next_st.config_control = pins.db;
				ADDR_FIFO: begin
					next_st.core_wr    = 1'b1;
					next_st.core_wdata = pins.db;
				end
				default: ;
			endcase
		end

		if (tc_rise) begin
			next_st.core_tc = 1'b1;
		end

		// Request drops as soon as the grant is seen
		next_st.dma_request_out = core_xfer_req_i & ~core_non_dma_i & ~grant;
		next_st.irq = (core_xfer_req_i & core_non_dma_i) | core_result_valid_i;

		if (core_spec_load_i) begin
			next_st.head_unload_timer = core_spec_value_i;
		end

		// Pin reset idles the port but keeps the specify timer values
		if (st.soft_rst) begin
			next_st.drive_output_control        = DOR_RESET;
			next_st.dsr        = DSR_RESET;
			next_st.config_control        = CCR_RESET;
			next_st.dout       = IDLE_DATA;
			next_st.dout_oe    = 1'b0;
			next_st.dma_request_out        = 1'b0;
			next_st.irq        = 1'b0;
			next_st.core_wr    = 1'b0;
			next_st.core_rd    = 1'b0;
			next_st.core_tc    = 1'b0;
			next_st.core_wdata = IDLE_DATA;
		end

		if (srst_i) begin
			next_st          = '0;
			next_st.drive_output_control      = DOR_RESET;
			next_st.dsr      = DSR_RESET;
			next_st.config_control      = CCR_RESET;
			next_st.head_unload_timer      = HUT_RESET;
			next_st.rd_prev  = 1'b1;
			next_st.wr_prev  = 1'b1;
			next_st.tc_prev  = 1'b1;
			next_st.pc_mode  = pins.ident;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign data_o                 = st.dout;
	assign data_oe_o              = st.dout_oe;
	assign dma_request_out_o      = st.dma_request_out;
	assign dma_request_out_oe_o   = ~gate_float;
	assign irq_o                  = st.irq;
	assign irq_oe_o               = ~gate_float;
	assign core_write_o           = st.core_wr;
	assign core_write_data_o      = st.core_wdata;
	assign core_read_o            = st.core_rd;
	assign core_tc_o              = st.core_tc;
	assign port_reset_o           = st.soft_rst;
	assign pc_mode_o              = st.pc_mode;
	assign osc_tick_o             = tick;
	assign drive_output_control_o = st.drive_output_control;
	assign rate_select_o          = st.dsr;
	assign config_control_o       = st.config_control;
	assign head_unload_timer_o    = st.head_unload_timer;
endmodule

// ===== fhp_port_properties.sv
module fhp_port_properties (
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic       cs_n_i,
	input wire logic       rd_n_i,
	input wire logic [2:0] addr_i,
	input wire logic       dma_grant_in_n_i,
	input wire logic       core_xfer_req_i,
	input wire logic       core_non_dma_i,
	input wire logic       core_result_valid_i,
	input wire logic       data_oe_o,
	input wire logic       dma_request_out_o,
	input wire logic       dma_request_out_oe_o,
	input wire logic       irq_o,
	input wire logic       irq_oe_o,
	input wire logic       core_write_o,
	input wire logic       core_tc_o,
	input wire logic       port_reset_o,
	input wire logic       pc_mode_o,
	input wire logic [7:0] drive_output_control_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	a_srst_idle: assert property ($fell(srst_i) |-> !dma_request_out_o && !irq_o
		&& drive_output_control_o == 8'h00 && !data_oe_o && dma_request_out_oe_o)
		else $error("port not idle after reset");
	a_irq_cause: assert property (!port_reset_o |=> port_reset_o
		|| irq_o == ($past(core_xfer_req_i) && $past(core_non_dma_i) || $past(core_result_valid_i)))
		else $error("interrupt level wrong");
	a_drq_cause: assert property (dma_request_out_o
		|-> $past(core_xfer_req_i) && !$past(core_non_dma_i))
		else $error("dma request without cause");
	a_grant_drops_drq: assert property ($fell(dma_grant_in_n_i) ##1
		!dma_grant_in_n_i [*6] |-> !dma_request_out_o)
		else $error("dma request held during grant");
	a_tc_in_grant: assert property (core_tc_o |-> !$past(dma_grant_in_n_i, 5))
		else $error("terminal count outside grant");
	a_rsvd_quiet: assert property ((!cs_n_i && !rd_n_i && addr_i == 3'h3) [*6] |-> !data_oe_o)
		else $error("reserved read drives bus");
	a_write_pulse: assert property (core_write_o |=> !core_write_o)
		else $error("write pulse too long");
	a_float_gate: assert property (dma_request_out_oe_o == !(pc_mode_o
		&& drive_output_control_o[3]) && irq_oe_o == dma_request_out_oe_o)
		else $error("output float gating wrong");
endmodule

bind fhp_port fhp_port_properties u_fhp_port_properties (.*);

// ===== fhp_host.sv
module fhp_host (
	input  wire logic       clk_i,
	input  wire logic [7:0] data_i,
	input  wire logic       oe_i,
	output logic            cs_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic [2:0]      addr_o,
	output logic [7:0]      db_o,
	output logic            grant_n_o,
	output logic            tc_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{cs_n_o, rd_n_o, wr_n_o, grant_n_o, tc_o} = 5'h1e;
		addr_o = 3'h0;
		db_o = 8'h00;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel);
		{cs_n_o, addr_o, db_o, wr_n_o} = {!sel, a, d, 1'b0};
		step(5);
		wr_n_o = 1'b1;
		step(6);
		{cs_n_o, db_o} = {1'b1, ~d};
		step(1);
	endtask
	task automatic rd(input logic [2:0] a, input logic sel, output logic [7:0] d, output logic oe);
		{cs_n_o, addr_o, rd_n_o} = {!sel, a, 1'b0};
		step(6);
		{d, oe} = {data_i, oe_i};
		rd_n_o = 1'b1;
		step(6);
		cs_n_o = 1'b1;
		step(1);
	endtask
	// Grant replaces select; terminal count is driven to act only inside the strobe, to its inverse after
	task automatic dma(input logic act, input logic gnt, output logic [7:0] d);
		grant_n_o = !gnt;
		step(6);
		{rd_n_o, tc_o} = {1'b0, act};
		step(6);
		d = data_i;
		{rd_n_o, tc_o} = {1'b1, !act};
		step(6);
		grant_n_o = 1'b1;
		step(1);
	endtask
endmodule

// ===== fhp_port_test.sv
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module fhp_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_i = 1'b0, srst_i = 1'b1, reset_pin_i = 1'b0, ident_i = 1'b1;
	logic       xfer = 1'b0, non_dma = 1'b0, res_v = 1'b0, spec_ld = 1'b0, oe;
	logic [7:0] spec_v = 8'h3c, rdat;
	logic [7:0] c_rd = 8'h59, c_sa = 8'h15, c_sb = 8'h26, c_ms = 8'h37, c_di = 8'h48;
	int         rd_seen = 0, tick_seen = 0, t0;
	wire logic  cwr, crd, tck;
	wire logic [7:0] cwd;
	logic [7:0] exp_rd [8] = '{8'h15, 8'h26, 8'h0c, 8'h00, 8'h37, 8'h59, 8'h00, 8'h48};
	int         failures = 0, check_count = 0, tc_seen = 0, i;
	wire logic  cs_n, rd_n, wr_n, gnt_n, tc, doe, dma_request_out, drq_oe, irq, irq_oe, core_tc, prst, pcm;
	wire logic [2:0] addr;
	wire logic [7:0] db, dout, drive_output_control, rate, cfg, head_unload_timer;
	fhp_host u_fhp_host (.clk_i, .data_i(dout), .oe_i(doe), .cs_n_o(cs_n), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .addr_o(addr), .db_o(db), .grant_n_o(gnt_n), .tc_o(tc));
	fhp_port u_fhp_port (.clk_i, .srst_i, .reset_pin_i, .ident_i, .cs_n_i(cs_n), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .addr_i(addr), .data_i(db), .data_o(dout), .data_oe_o(doe),
		.dma_grant_in_n_i(gnt_n), .transfer_end_count_i(tc), .dma_request_out_o(dma_request_out),
		.dma_request_out_oe_o(drq_oe), .irq_o(irq), .irq_oe_o(irq_oe), .core_xfer_req_i(xfer),
		.core_non_dma_i(non_dma), .core_result_valid_i(res_v), .core_rd_data_i(c_rd),
		.core_status_a_i(c_sa), .core_status_b_i(c_sb), .core_main_status_i(c_ms),
		.core_drive_input_i(c_di), .core_spec_load_i(spec_ld), .core_spec_value_i(spec_v),
		.core_write_o(cwr), .core_write_data_o(cwd), .core_read_o(crd), .core_tc_o(core_tc),
		.port_reset_o(prst), .pc_mode_o(pcm), .osc_tick_o(tck), .drive_output_control_o(drive_output_control),
		.rate_select_o(rate), .config_control_o(cfg), .head_unload_timer_o(head_unload_timer));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (core_tc === 1'b1) tc_seen++;
	always @(posedge clk_i) if (crd === 1'b1) rd_seen++;
	always @(posedge clk_i) if (tck === 1'b1) tick_seen++;
	task automatic end_sim();
		if (failures == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		u_fhp_host.step(5);
		srst_i = 1'b0;
		u_fhp_host.step(4);
		`CHK("mode", 1'b1, pcm)
		`CHK("dor", 8'h00, drive_output_control)
		u_fhp_host.wr(3'h2, 8'h0c, 1'b1);
		`CHK("dor", 8'h0c, drive_output_control)
		`CHK("irq oe", 1'b0, irq_oe)
		`CHK("drq oe", 1'b0, drq_oe)
		u_fhp_host.wr(3'h4, 8'h5a, 1'b1);
		u_fhp_host.wr(3'h7, 8'ha5, 1'b1);
		u_fhp_host.wr(3'h3, 8'hff, 1'b1);
		u_fhp_host.wr(3'h6, 8'hff, 1'b1);
		u_fhp_host.wr(3'h0, 8'hff, 1'b1);
		u_fhp_host.wr(3'h2, 8'hff, 1'b0);
		u_fhp_host.wr(3'h5, 8'h6b, 1'b1);
		`CHK("fifo write", 8'h6b, cwd)
		t0 = tick_seen;
		u_fhp_host.step(200);
		`CHK("tick count", 24, tick_seen - t0)
		`CHK("rate", 8'h5a, rate)
		`CHK("cfg", 8'ha5, cfg)
		`CHK("dor", 8'h0c, drive_output_control)
		for (int k = 0; k < 8; k++) begin
			u_fhp_host.rd(k[2:0], 1'b1, rdat, oe);
			`CHK("read data", exp_rd[k], rdat)
			`CHK("read oe", 1'(k != 3 && k != 6), oe)
		end
		`CHK("fifo reads", 1, rd_seen)
		c_rd = 8'h9a;
		u_fhp_host.wr(3'h2, 8'h00, 1'b1);
		xfer = 1'b1;
		u_fhp_host.step(2);
		`CHK("drq", 1'b1, dma_request_out)
		u_fhp_host.dma(1'b1, 1'b1, rdat);
		`CHK("dma read", 8'h9a, rdat)
		`CHK("fifo reads", 2, rd_seen)
		`CHK("tc count", 1, tc_seen)
		u_fhp_host.dma(1'b1, 1'b0, rdat);
		`CHK("tc count", 1, tc_seen)
		non_dma = 1'b1;
		u_fhp_host.step(2);
		`CHK("irq", 1'b1, irq)
		`CHK("drq", 1'b0, dma_request_out)
		{xfer, non_dma, res_v, spec_ld} = 4'h3;
		u_fhp_host.step(1);
		spec_ld = 1'b0;
		`CHK("irq", 1'b1, irq)
		reset_pin_i = 1'b1;
		for (i = 0; i < 300 && prst !== 1'b1; i++) u_fhp_host.step(1);
		`CHK("pin reset", 1'b1, prst)
		if (prst !== 1'b1) end_sim();
		u_fhp_host.step(2);
		`CHK("irq", 1'b0, irq)
		`CHK("rate", 8'h00, rate)
		`CHK("timer", 8'h3c, head_unload_timer)
		{reset_pin_i, res_v, srst_i, ident_i} = 4'h2;
		u_fhp_host.tc_o = 1'b1;
		u_fhp_host.step(5);
		srst_i = 1'b0;
		u_fhp_host.step(4);
		`CHK("mode", 1'b0, pcm)
		u_fhp_host.wr(3'h2, 8'h08, 1'b1);
		`CHK("drq oe", 1'b1, drq_oe)
		u_fhp_host.rd(3'h1, 1'b1, rdat, oe);
		`CHK("status b", 8'h26, rdat)
		tc_seen = 0;
		u_fhp_host.dma(1'b0, 1'b1, rdat);
		`CHK("tc count", 1, tc_seen)
		end_sim();
	end
endmodule
